/* pin_and_serial_option_regs.sv */
// axi4-lite register slice for three multiplexed pins and serial port 5/6 options
// assumes word accesses; byte lane 0 carries the 8-bit register, upper bits read zero
// Summary of operation
// - config bit 0 sets pin direction, one input, zero output.
// - config bit 1 inverts pin value between pad and logic when one.
// - config bit 7 selects open-drain when one, push-pull when zero.
// - with port 3 present, bit 2 at 2B routes its request-to-send to pin.
// - without port 3, bits 6 to 2 at 2B are reserved.
// - register 2B resets to 01, non-inverted push-pull input.
// - 2C bits 3:2 select keyboard data, edge interrupt 0, reserved or gpio.
// - 2D bits 3:2 select keyboard clock, edge interrupt 1, reserved or gpio.
// - registers 2C and 2D reset to 8C, keyboard, open drain, output.
// - fifo shadow fields: enable, rx reset, tx reset, dma, trigger 7:6.
// - port 5 shadow read-only at 2E, port 6 at 2F, last written values.
// - without ports 5 and 6, their shadow and option registers are reserved.
// - option bit 0 drives control-out from request-to-send or terminal-ready.
// - option bits 2:1 route control-in to carrier, ring, clear or set-ready.
// - option bit 3 enables automatic transmit-direction control.
// - option bit 4 picks request-to-send or terminal-ready for direction control.
// - option bit 5 sets direction level while transmitting; bits 7:6 reserved.
// - port 5 and 6 option registers reset to 04.
`timescale 1ns/100ps
module pin_and_serial_option_regs
#(
    parameter int ADDR_W = 12,
    parameter bit HAS_PORT3 = 1'b1,
    parameter bit HAS_PORT56 = 1'b1
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] pin_pad_in,
    output logic [2:0] pin_pad_out,
    output logic [2:0] pin_pad_oe_n,
    input wire logic [2:0] gpio_out_value,
    output logic [2:0] gpio_in_value,
    input wire logic port3_request_to_send_out,
    input wire logic keyboard_data_line_out,
    input wire logic keyboard_clock_line_out,
    output logic keyboard_data_line_in,
    output logic keyboard_clock_line_in,
    output logic [1:0] edge_irq,
    input wire logic port5_fifo_ctrl_wr,
    input wire logic [7:0] port5_fifo_ctrl_data,
    input wire logic port6_fifo_ctrl_wr,
    input wire logic [7:0] port6_fifo_ctrl_data,
    input wire logic port5_request_to_send_n,
    input wire logic port5_terminal_ready_n,
    input wire logic port5_transmit_active,
    output logic port5_control_out_pin,
    input wire logic port5_control_in_pin,
    output logic port5_carrier_detect_n,
    output logic port5_ring_indicator_n,
    output logic port5_clear_to_send_n,
    output logic port5_set_ready_n
);
    localparam logic [7:0] PIN17_MASK = HAS_PORT3 ?
        (pin_serial_opt_pkg::MASK_PIN_BASIC | pin_serial_opt_pkg::MASK_PIN_PORT3_ALT) :
        pin_serial_opt_pkg::MASK_PIN_BASIC;
    localparam logic [7:0] SHADOW_MASK = HAS_PORT56 ?
        pin_serial_opt_pkg::MASK_FIFO_SHADOW : 8'h00;
    localparam logic [7:0] OPT_MASK = HAS_PORT56 ?
        pin_serial_opt_pkg::MASK_SERIAL_OPTIONS : 8'h00;

    logic [7:0] pin_cfg_q [3];
    logic [7:0] shadow5_q;
    logic [7:0] shadow6_q;
    logic [7:0] opt5_q;
    logic [7:0] opt6_q;

    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wlane0_q;
    logic aw_full_q;
    logic w_full_q;
    logic do_write;
    logic [6:0] widx;
    logic wmapped;

    logic [2:0] alt_en;
    logic [2:0] alt_val;
    logic [2:0] in_val;
    logic [2:0] in_edge;
    logic [1:0] func_data;
    logic [1:0] func_clock;

    // index decode; address bits above the index must be zero
    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        logic [6:0] idx;
        idx = addr[8:2];
        mapped = (addr[ADDR_W-1:9] == '0)
            && (idx >= pin_serial_opt_pkg::IDX_PIN_CONFIG_B17)
            && (idx <= pin_serial_opt_pkg::IDX_PORT6_SERIAL_OPTIONS);
    endfunction : mapped

    // write channel handshakes; address and data may arrive in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            aw_full_q <= 1'b0;
            awaddr_q <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_full_q <= 1'b0;
        end
        else if (!aw_full_q && !s_axi_bvalid)
        begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_wready <= 1'b0;
            w_full_q <= 1'b0;
            wdata_q <= 8'h00;
            wlane0_q <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wlane0_q <= s_axi_wstrb[0];
        end
        else if (do_write)
        begin
            w_full_q <= 1'b0;
        end
        else if (!w_full_q && !s_axi_bvalid)
        begin
            s_axi_wready <= 1'b1;
        end
    end

    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    assign widx = awaddr_q[8:2];
    assign wmapped = mapped(awaddr_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pin_serial_opt_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wmapped ? pin_serial_opt_pkg::RESP_OKAY :
                pin_serial_opt_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // software-written configuration; reserved bits never stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_cfg_q[0] <= pin_serial_opt_pkg::RST_PIN_CONFIG_B17 & PIN17_MASK;
            pin_cfg_q[1] <= pin_serial_opt_pkg::RST_KBD_PIN_CONFIG;
            pin_cfg_q[2] <= pin_serial_opt_pkg::RST_KBD_PIN_CONFIG;
            opt5_q <= pin_serial_opt_pkg::RST_SERIAL_OPTIONS & OPT_MASK;
            opt6_q <= pin_serial_opt_pkg::RST_SERIAL_OPTIONS & OPT_MASK;
        end
        else if (do_write && wmapped && wlane0_q)
        begin
            case (widx)
                pin_serial_opt_pkg::IDX_PIN_CONFIG_B17:
                    pin_cfg_q[0] <= wdata_q & PIN17_MASK;
                pin_serial_opt_pkg::IDX_KBD_DATA_PIN_CONFIG:
                    pin_cfg_q[1] <= wdata_q & pin_serial_opt_pkg::MASK_KBD_PIN;
                pin_serial_opt_pkg::IDX_KBD_CLOCK_PIN_CONFIG:
                    pin_cfg_q[2] <= wdata_q & pin_serial_opt_pkg::MASK_KBD_PIN;
                pin_serial_opt_pkg::IDX_PORT5_SERIAL_OPTIONS:
                    opt5_q <= wdata_q & OPT_MASK;
                pin_serial_opt_pkg::IDX_PORT6_SERIAL_OPTIONS:
                    opt6_q <= wdata_q & OPT_MASK;
                default:
                    ; // shadows are read-only
            endcase
        end
    end

    // shadows follow the serial cores' own fifo control writes, not the bus
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shadow5_q <= pin_serial_opt_pkg::RST_FIFO_CTRL_SHADOW;
            shadow6_q <= pin_serial_opt_pkg::RST_FIFO_CTRL_SHADOW;
        end
        else
        begin
            if (port5_fifo_ctrl_wr)
                shadow5_q <= port5_fifo_ctrl_data & SHADOW_MASK;
            if (port6_fifo_ctrl_wr)
                shadow6_q <= port6_fifo_ctrl_data & SHADOW_MASK;
        end
    end

    // read channel: one read at a time, data one cycle after address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pin_serial_opt_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? pin_serial_opt_pkg::RESP_OKAY :
                pin_serial_opt_pkg::RESP_SLVERR;
            case (s_axi_araddr[8:2])
                pin_serial_opt_pkg::IDX_PIN_CONFIG_B17:
                    s_axi_rdata <= {24'h00_0000, pin_cfg_q[0]};
                pin_serial_opt_pkg::IDX_KBD_DATA_PIN_CONFIG:
                    s_axi_rdata <= {24'h00_0000, pin_cfg_q[1]};
                pin_serial_opt_pkg::IDX_KBD_CLOCK_PIN_CONFIG:
                    s_axi_rdata <= {24'h00_0000, pin_cfg_q[2]};
                pin_serial_opt_pkg::IDX_PORT5_FIFO_CTRL_SHADOW:
                    s_axi_rdata <= {24'h00_0000, shadow5_q};
                pin_serial_opt_pkg::IDX_PORT6_FIFO_CTRL_SHADOW:
                    s_axi_rdata <= {24'h00_0000, shadow6_q};
                pin_serial_opt_pkg::IDX_PORT5_SERIAL_OPTIONS:
                    s_axi_rdata <= {24'h00_0000, opt5_q};
                pin_serial_opt_pkg::IDX_PORT6_SERIAL_OPTIONS:
                    s_axi_rdata <= {24'h00_0000, opt6_q};
                default:
                    s_axi_rdata <= 32'h0000_0000;
            endcase
            if (!mapped(s_axi_araddr))
                s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end

    // pin function selection
    assign func_data = pin_cfg_q[1][pin_serial_opt_pkg::PIN_FUNC_LO +: 2];
    assign func_clock = pin_cfg_q[2][pin_serial_opt_pkg::PIN_FUNC_LO +: 2];
    assign alt_en[0] = HAS_PORT3 && pin_cfg_q[0][pin_serial_opt_pkg::PIN_ALT_BIT];
    assign alt_en[1] = func_data == pin_serial_opt_pkg::FUNC_KEYBOARD;
    assign alt_en[2] = func_clock == pin_serial_opt_pkg::FUNC_KEYBOARD;
    assign alt_val[0] = port3_request_to_send_out;
    // keyboard lines are open drain by default; the direction bit must stay zero
    assign alt_val[1] = keyboard_data_line_out;
    assign alt_val[2] = keyboard_clock_line_out;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_pin
            pin_pad_cell u_cell
            (
                .aclk(aclk),
                .aresetn(aresetn),
                .cfg(pin_cfg_q[gi]),
                .alt_en(alt_en[gi]),
                .alt_val(alt_val[gi]),
                .gpio_val(gpio_out_value[gi]),
                .pad_in(pin_pad_in[gi]),
                .pad_out(pin_pad_out[gi]),
                .pad_oe_n(pin_pad_oe_n[gi]),
                .in_val(in_val[gi]),
                .in_edge(in_edge[gi])
            );
        end
    endgenerate

    // logic-side views of the pins; keyboard lines idle high when not selected
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gpio_in_value <= 3'b000;
            keyboard_data_line_in <= 1'b1;
            keyboard_clock_line_in <= 1'b1;
            edge_irq <= 2'b00;
        end
        else
        begin
            gpio_in_value <= in_val;
            keyboard_data_line_in <= alt_en[1] ? in_val[1] : 1'b1;
            keyboard_clock_line_in <= alt_en[2] ? in_val[2] : 1'b1;
            edge_irq[0] <= in_edge[1] && (func_data == pin_serial_opt_pkg::FUNC_EDGE_IRQ);
            edge_irq[1] <= in_edge[2] && (func_clock == pin_serial_opt_pkg::FUNC_EDGE_IRQ);
        end
    end

    // port 5 modem routing; direction control overrides the chosen modem output
    logic auto_on;
    logic dir_level_n;
    logic rts_eff_n;
    logic dtr_eff_n;
    logic [1:0] in_sel;

    assign auto_on = opt5_q[pin_serial_opt_pkg::OPT_AUTO_EN_BIT];
    // polarity zero drives low while transmitting, one drives high
    assign dir_level_n = port5_transmit_active ?
        opt5_q[pin_serial_opt_pkg::OPT_AUTO_POL_BIT] :
        !opt5_q[pin_serial_opt_pkg::OPT_AUTO_POL_BIT];
    assign rts_eff_n = (auto_on && opt5_q[pin_serial_opt_pkg::OPT_AUTO_RTS_BIT]) ?
        dir_level_n : port5_request_to_send_n;
    assign dtr_eff_n = (auto_on && !opt5_q[pin_serial_opt_pkg::OPT_AUTO_RTS_BIT]) ?
        dir_level_n : port5_terminal_ready_n;
    assign in_sel = opt5_q[pin_serial_opt_pkg::OPT_IN_SEL_LO +: 2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port5_control_out_pin <= 1'b1;
            port5_carrier_detect_n <= 1'b1;
            port5_ring_indicator_n <= 1'b1;
            port5_clear_to_send_n <= 1'b1;
            port5_set_ready_n <= 1'b1;
        end
        else
        begin
            port5_control_out_pin <= opt5_q[pin_serial_opt_pkg::OPT_OUT_SEL_BIT] ?
                rts_eff_n : dtr_eff_n;
            // unselected modem inputs sit inactive (high)
            port5_carrier_detect_n <= (in_sel == pin_serial_opt_pkg::IN_SEL_CARRIER) ?
                port5_control_in_pin : 1'b1;
            port5_ring_indicator_n <= (in_sel == pin_serial_opt_pkg::IN_SEL_RING) ?
                port5_control_in_pin : 1'b1;
            port5_clear_to_send_n <= (in_sel == pin_serial_opt_pkg::IN_SEL_CLEAR_TO_SEND) ?
                port5_control_in_pin : 1'b1;
            port5_set_ready_n <= (in_sel == pin_serial_opt_pkg::IN_SEL_SET_READY) ?
                port5_control_in_pin : 1'b1;
        end
    end

endmodule : pin_and_serial_option_regs

/* pin_serial_opt_pkg.sv */
// constants for the pin configuration and serial option register slice
// assumes word-aligned axi4-lite access, register index times four is the byte address
package pin_serial_opt_pkg;

    // register indices; byte address is four times the index
    localparam logic [6:0] IDX_PIN_CONFIG_B17 = 7'h2B;
    localparam logic [6:0] IDX_KBD_DATA_PIN_CONFIG = 7'h2C;
    localparam logic [6:0] IDX_KBD_CLOCK_PIN_CONFIG = 7'h2D;
    localparam logic [6:0] IDX_PORT5_FIFO_CTRL_SHADOW = 7'h2E;
    localparam logic [6:0] IDX_PORT6_FIFO_CTRL_SHADOW = 7'h2F;
    localparam logic [6:0] IDX_PORT5_SERIAL_OPTIONS = 7'h30;
    localparam logic [6:0] IDX_PORT6_SERIAL_OPTIONS = 7'h31;

    // reset values
    localparam logic [7:0] RST_PIN_CONFIG_B17 = 8'h01;
    localparam logic [7:0] RST_KBD_PIN_CONFIG = 8'h8C;
    localparam logic [7:0] RST_FIFO_CTRL_SHADOW = 8'h00;
    localparam logic [7:0] RST_SERIAL_OPTIONS = 8'h04;

    // writable / readable bit masks
    localparam logic [7:0] MASK_PIN_BASIC = 8'h83;
    localparam logic [7:0] MASK_PIN_PORT3_ALT = 8'h04;
    localparam logic [7:0] MASK_KBD_PIN = 8'h8F;
    localparam logic [7:0] MASK_FIFO_SHADOW = 8'hCF;
    localparam logic [7:0] MASK_SERIAL_OPTIONS = 8'h3F;

    // pin configuration fields
    localparam int PIN_DIR_BIT = 0;
    localparam int PIN_POL_BIT = 1;
    localparam int PIN_ALT_BIT = 2;
    localparam int PIN_FUNC_LO = 2;
    localparam int PIN_OD_BIT = 7;

    // pin function encodings for the keyboard pins
    localparam logic [1:0] FUNC_GPIO = 2'b00;
    localparam logic [1:0] FUNC_RSVD = 2'b01;
    localparam logic [1:0] FUNC_EDGE_IRQ = 2'b10;
    localparam logic [1:0] FUNC_KEYBOARD = 2'b11;

    // serial option fields
    localparam int OPT_OUT_SEL_BIT = 0;
    localparam int OPT_IN_SEL_LO = 1;
    localparam int OPT_AUTO_EN_BIT = 3;
    localparam int OPT_AUTO_RTS_BIT = 4;
    localparam int OPT_AUTO_POL_BIT = 5;

    // control-in routing encodings
    localparam logic [1:0] IN_SEL_SET_READY = 2'b00;
    localparam logic [1:0] IN_SEL_CLEAR_TO_SEND = 2'b01;
    localparam logic [1:0] IN_SEL_RING = 2'b10;
    localparam logic [1:0] IN_SEL_CARRIER = 2'b11;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pin_serial_opt_pkg

/* pin_pad_cell.sv */
// one multiplexed i/o pin: direction, polarity, driver type, alternate output
// assumes the pad wire level is resolved outside from pad_out and pad_oe_n
`timescale 1ns/100ps
module pin_pad_cell
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] cfg,
    input wire logic alt_en,
    input wire logic alt_val,
    input wire logic gpio_val,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n,
    output logic in_val,
    output logic in_edge
);
    logic out_level;
    logic drive;

    // polarity sits between pad and logic for both directions
    assign out_level = (alt_en ? alt_val : gpio_val) ^ cfg[pin_serial_opt_pkg::PIN_POL_BIT];
    // open drain only pulls low; a high level releases the pad
    assign drive = !cfg[pin_serial_opt_pkg::PIN_DIR_BIT]
        && (!cfg[pin_serial_opt_pkg::PIN_OD_BIT] || !out_level);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_out <= 1'b0;
            pad_oe_n <= 1'b1;
        end
        else
        begin
            pad_out <= out_level;
            pad_oe_n <= !drive;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_val <= 1'b0;
            in_edge <= 1'b0;
        end
        else
        begin
            in_val <= pad_in ^ cfg[pin_serial_opt_pkg::PIN_POL_BIT];
            in_edge <= (pad_in ^ cfg[pin_serial_opt_pkg::PIN_POL_BIT]) != in_val;
        end
    end

endmodule : pin_pad_cell

/* pin_serial_opt_properties.sv */
// checker for the pin and serial option register slice
// assumes binding to pin_and_serial_option_regs, one clock domain
`timescale 1ns/100ps
module pin_serial_opt_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] pin_pad_in,
    input wire logic [1:0] edge_irq,
    input wire logic port5_control_in_pin,
    input wire logic port5_carrier_detect_n,
    input wire logic port5_ring_indicator_n,
    input wire logic port5_clear_to_send_n,
    input wire logic port5_set_ready_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [3:0] modem_n;
    assign modem_n = {port5_carrier_detect_n, port5_ring_indicator_n,
                      port5_clear_to_send_n, port5_set_ready_n};
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    AST_EDGE0: assert property (edge_irq[0] |-> $past(pin_pad_in[1], 2) != $past(pin_pad_in[1], 3))
        else $error("edge pulse 0 without edge");
    AST_EDGE1: assert property (edge_irq[1] |-> $past(pin_pad_in[2], 2) != $past(pin_pad_in[2], 3))
        else $error("edge pulse 1 without edge");
    AST_MODEM_IDLE: assert property ($past(port5_control_in_pin) |-> modem_n == 4'hF)
        else $error("modem input active while pin idle");
    AST_MODEM_ONE: assert property ($onehot0(~modem_n))
        else $error("several modem inputs active");
    COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    COV_EDGE: cover property (edge_irq[0]);
    COV_MODEM: cover property (!port5_carrier_detect_n);
endmodule : pin_serial_opt_checker

bind pin_and_serial_option_regs pin_serial_opt_checker u_chk (.*);

/* test_pin_and_serial_option_regs.sv */
// self-checking bench for the pin and serial option register slice
// assumes default parameters: port 3 and ports 5/6 present
`timescale 1ns/100ps
module test_pin_and_serial_option_regs;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, edge_irq;
    logic [2:0] pin_pad_in = 3'h0, gpio_out_value = 3'h0, pin_pad_out, pin_pad_oe_n, gpio_in_value;
    logic port3_request_to_send_out = 1'h0, keyboard_data_line_out = 1'h0;
    logic keyboard_clock_line_out = 1'h0, keyboard_data_line_in, keyboard_clock_line_in;
    logic port5_fifo_ctrl_wr = 1'h0, port6_fifo_ctrl_wr = 1'h0;
    logic [7:0] port5_fifo_ctrl_data = 8'h00, port6_fifo_ctrl_data = 8'h00;
    logic port5_request_to_send_n = 1'h1, port5_terminal_ready_n = 1'h1;
    logic port5_transmit_active = 1'h0, port5_control_in_pin = 1'h1, port5_control_out_pin;
    logic port5_carrier_detect_n, port5_ring_indicator_n, port5_clear_to_send_n;
    logic port5_set_ready_n;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] ec0 = 8'h00, ec1 = 8'h00;
    logic [15:0] e;
    logic [7:0] rst_v [7] = '{8'h01, 8'h8C, 8'h8C, 8'h00, 8'h00, 8'h04, 8'h04};
    logic [7:0] msk [7] = '{8'h87, 8'h8F, 8'h8F, 8'h00, 8'h00, 8'h3F, 8'h3F};
    logic [7:0] pcfg [6] = '{8'h00, 8'h02, 8'h80, 8'h80, 8'h04, 8'h04};
    logic [1:0] pexp [6] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h0, 2'h2};
    logic [7:0] ocfg [6] = '{8'h01, 8'h00, 8'h19, 8'h19, 8'h39, 8'h08};
    logic [2:0] oin [6] = '{3'h2, 3'h2, 3'h7, 3'h2, 3'h3, 3'h7};

    pin_and_serial_option_regs u_dut (.*);

    always #12.5 aclk = ~aclk;

    // edge pulses last one cycle, so they are counted rather than sampled
    always @(posedge aclk)
    begin
        ec0 <= ec0 + {7'h00, edge_irq[0]};
        ec1 <= ec1 + {7'h00, edge_irq[1]};
    end

    task automatic final_report;
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tmo(input int n);
        if (n >= 40)
        begin
            n_errors++;
            final_report();
        end
    endtask : tmo

    function automatic logic [11:0] ba(input int i);
        return {3'h0, pin_serial_opt_pkg::IDX_PIN_CONFIG_B17 + 7'(i), 2'h0};
    endfunction : ba

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er,
                      input logic [3:0] st = 4'hF);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        tmo(n);
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] ex, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        tmo(n);
        chk("rdata", s_axi_rdata, {24'h000000, ex});
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        final_report();
    end

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 7; i++)
            rd(ba(i), rst_v[i], 2'h0);
        for (int i = 0; i < 7; i++)
        begin
            wr(ba(i), 8'hFF, 2'h0);
            rd(ba(i), msk[i], 2'h0);
        end
        wr(ba(5), 8'h00, 2'h0, 4'h0);
        rd(ba(5), 8'h3F, 2'h0);
        wr(12'h0A8, 8'hFF, 2'h2);
        wr(12'h8AC, 8'h00, 2'h2);
        rd(12'h0A8, 8'h00, 2'h2);
        rd(ba(0), 8'h87, 2'h0);
        port5_fifo_ctrl_data <= 8'hFF;
        port6_fifo_ctrl_data <= 8'h3A;
        port5_fifo_ctrl_wr <= 1'h1;
        port6_fifo_ctrl_wr <= 1'h1;
        @(posedge aclk);
        port5_fifo_ctrl_wr <= 1'h0;
        port6_fifo_ctrl_wr <= 1'h0;
        rd(ba(3), 8'hCF, 2'h0);
        rd(ba(4), 8'h0A, 2'h0);
        // alternate value kept opposite to gpio, except at i == 3 where both are low, so a wrong source shows
        for (int i = 0; i < 6; i++)
        begin
            wr(ba(0), pcfg[i], 2'h0);
            gpio_out_value <= {2'h0, ~i[0] | (i == 2)};
            port3_request_to_send_out <= i[0] & (i != 3);
            repeat (3) @(posedge aclk);
            chk("pad0", {30'h0, pin_pad_out[0], pin_pad_oe_n[0]},
                {30'h0, pexp[i]});
        end
        wr(ba(0), 8'h03, 2'h0);
        pin_pad_in <= 3'h1;
        repeat (4) @(posedge aclk);
        chk("gpin", {30'h0, gpio_in_value[0], pin_pad_oe_n[0]}, 32'h1);
        wr(ba(1), 8'h0C, 2'h0);
        wr(ba(2), 8'h0C, 2'h0);
        keyboard_data_line_out <= 1'h1;
        pin_pad_in <= 3'h4;
        repeat (4) @(posedge aclk);
        chk("kpad", {28'h0, pin_pad_out[2:1], pin_pad_oe_n[2:1]}, 32'h4);
        chk("kin", {30'h0, keyboard_clock_line_in, keyboard_data_line_in}, 32'h2);
        wr(ba(1), 8'h09, 2'h0);
        wr(ba(2), 8'h09, 2'h0);
        chk("kidle", {30'h0, keyboard_clock_line_in, keyboard_data_line_in}, 32'h3);
        e = {ec1, ec0};
        pin_pad_in <= 3'h6;
        repeat (5) @(posedge aclk);
        chk("edge0", {16'h0, ec1, ec0}, {16'h0, e + 16'h0001});
        pin_pad_in <= 3'h2;
        repeat (5) @(posedge aclk);
        chk("edge1", {16'h0, ec1, ec0}, {16'h0, e + 16'h0101});
        wr(ba(1), 8'h01, 2'h0);
        pin_pad_in <= 3'h0;
        repeat (5) @(posedge aclk);
        chk("edgeoff", {16'h0, ec1, ec0}, {16'h0, e + 16'h0101});
        for (int i = 0; i < 6; i++)
        begin
            wr(ba(5), ocfg[i], 2'h0);
            {port5_request_to_send_n, port5_terminal_ready_n, port5_transmit_active} <= oin[i];
            repeat (3) @(posedge aclk);
            chk("ctlout", {31'h0, port5_control_out_pin},
                {31'h0, 1'(6'h1A >> i)});
        end
        for (int s = 0; s < 4; s++)
        begin
            wr(ba(5), {5'h00, 2'(s), 1'h0}, 2'h0);
            port5_control_in_pin <= 1'h0;
            repeat (3) @(posedge aclk);
            chk("ctlin", {28'h0, port5_carrier_detect_n, port5_ring_indicator_n,
                port5_clear_to_send_n, port5_set_ready_n}, {28'h0, ~(4'h1 << s)});
            port5_control_in_pin <= 1'h1;
        end
        final_report();
    end
endmodule : test_pin_and_serial_option_regs
